/* File: status_event_map.svh */
`ifndef STATUS_EVENT_MAP_SVH
`define STATUS_EVENT_MAP_SVH

// Register selector: [4:3] group, [2:0] register kind
`define SEL_GROUP_DYN        2'h0
`define SEL_GROUP_REG        2'h1
`define SEL_GROUP_QUES       2'h2
`define SEL_GROUP_STD        2'h3
`define SEL_KIND_COND        3'h0
`define SEL_KIND_EVENT       3'h1
`define SEL_KIND_RISE        3'h2
`define SEL_KIND_FALL        3'h3
`define SEL_KIND_ENABLE      3'h4

// Dynamic-protection detail bits
`define DYN_SWITCHING_RATE   0
`define DYN_RINGING          1
`define DYN_CLAMP_HIGH       2
`define DYN_CLAMP_LOW        3
`define DYN_CLAMP_ANY        4
`define DYN_CURRENT          5
`define DYN_POWER            6

// Out-of-regulation detail bits
`define LOSS_IPEAK_HIGH      0
`define LOSS_IPEAK_LOW       1
`define LOSS_MOD_HIGH        2
`define LOSS_MOD_LOW         3
`define LOSS_PPEAK_HIGH      4
`define LOSS_PPEAK_LOW       5
`define LOSS_VPEAK_HIGH      6
`define LOSS_VPEAK_LOW       7
`define LOSS_BOTTOM_RES      8

// Questionable group summary positions
`define QUES_DYN_BIT         8
`define QUES_LOSS_BIT        10
`define QUES_UNUSED_BIT      15

// Standard event bits
`define STD_OPC_BIT          0
`define STD_QUERY_BIT        2
`define STD_DEVICE_BIT       3
`define STD_EXEC_BIT         4
`define STD_COMMAND_BIT      5
`define STD_POWER_BIT        7

// Reset values
`define RST_STD_EVENT        16'h0080
`define RST_MASK             16'h0000
`define RST_RISE             16'hFFFF
`define RST_FALL             16'h0000

`endif

/* File: status_event_pkg.sv */
`default_nettype none
package status_event_pkg;
  typedef logic [15:0] status_word_type;
  typedef logic [4:0]  status_select_type;
endpackage : status_event_pkg
`default_nettype wire

/* File: status_event_reporting.sv */
`timescale 1ns/10ps
`default_nettype none
`include "status_event_map.svh"

module status_event_reporting
  import status_event_pkg::*;
#(
  parameter int DataWidth = 16
)(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Command-side register access
  input  wire status_select_type    regSelect,
  input  wire logic                 regRead,
  input  wire logic                 regWrite,
  input  wire logic [DataWidth-1:0] regWriteData,
  output logic      [DataWidth-1:0] regReadData,
  output logic                      regReadValid,
  // Dynamic-protection trips
  input  wire logic                 switching_rate_trip,
  input  wire logic                 ringing_trip,
  input  wire logic                 modulator_high_clamp_trip,
  input  wire logic                 modulator_low_clamp_trip,
  input  wire logic                 modulator_any_clamp_trip,
  input  wire logic                 dynamic_current_trip,
  input  wire logic                 dynamic_power_trip,
  // Out-of-regulation causes
  input  wire logic                 peak_current_high_limit,
  input  wire logic                 peak_current_low_limit,
  input  wire logic                 modulator_high_saturation,
  input  wire logic                 modulator_low_saturation,
  input  wire logic                 peak_power_high_limit,
  input  wire logic                 peak_power_low_limit,
  input  wire logic                 peak_voltage_high_limit,
  input  wire logic                 peak_voltage_low_limit,
  input  wire logic                 bottom_resistance_reserved,
  // Other questionable conditions
  input  wire status_word_type      questionableIn,
  // Communication events, one-cycle pulses
  input  wire logic                 operationComplete,
  input  wire logic                 emptyBufferRead,
  input  wire logic                 replyInterrupted,
  input  wire logic                 buffersFull,
  input  wire logic                 deviceError,
  input  wire logic                 executionError,
  input  wire logic                 commandError,
  // Summaries
  output logic                      dynamic_protection_summary,
  output logic                      out_of_regulation_summary,
  output logic                      questionableSummary,
  output logic                      standardSummary
);

  status_word_type dynCond, regCond, quesCond;
  status_word_type dynPrev_reg, regPrev_reg, quesPrev_reg;
  status_word_type dynRise_reg, regRise_reg, quesRise_reg;
  status_word_type dynFall_reg, regFall_reg, quesFall_reg;
  status_word_type dynEvent_reg, regEvent_reg, quesEvent_reg, stdEvent_reg;
  status_word_type dynEnable_reg, regEnable_reg, quesEnable_reg, stdEnable_reg;
  status_word_type dynHit, regHit, quesHit, stdHit;
  logic            dynSummary, regSummary;
  logic      [1:0] selGroup;
  logic      [2:0] selKind;

  assign selGroup = regSelect[4:3];
  assign selKind  = regSelect[2:0];

  function automatic status_word_type qualify(input status_word_type prev, input status_word_type cond,
                                              input status_word_type rise, input status_word_type fall);
    qualify = (rise & cond & ~prev) | (fall & ~cond & prev);
  endfunction : qualify

  function automatic logic readsEvent(input logic rd, input logic [1:0] grp, input logic [1:0] want,
                                      input logic [2:0] kind);
    readsEvent = rd && grp == want && kind == `SEL_KIND_EVENT;
  endfunction : readsEvent

  always_comb
  begin
    dynCond = '0;
    dynCond[`DYN_SWITCHING_RATE] = switching_rate_trip;
    dynCond[`DYN_RINGING]        = ringing_trip;
    dynCond[`DYN_CLAMP_HIGH]     = modulator_high_clamp_trip;
    dynCond[`DYN_CLAMP_LOW]      = modulator_low_clamp_trip;
    dynCond[`DYN_CLAMP_ANY]      = modulator_any_clamp_trip;
    dynCond[`DYN_CURRENT]        = dynamic_current_trip;
    dynCond[`DYN_POWER]          = dynamic_power_trip;
  end

  always_comb
  begin
    regCond = '0;
    regCond[`LOSS_IPEAK_HIGH] = peak_current_high_limit;
    regCond[`LOSS_IPEAK_LOW]  = peak_current_low_limit;
    regCond[`LOSS_MOD_HIGH]   = modulator_high_saturation;
    regCond[`LOSS_MOD_LOW]    = modulator_low_saturation;
    regCond[`LOSS_PPEAK_HIGH] = peak_power_high_limit;
    regCond[`LOSS_PPEAK_LOW]  = peak_power_low_limit;
    regCond[`LOSS_VPEAK_HIGH] = peak_voltage_high_limit;
    regCond[`LOSS_VPEAK_LOW]  = peak_voltage_low_limit;
    regCond[`LOSS_BOTTOM_RES] = bottom_resistance_reserved;
  end

  assign dynSummary = |(dynEvent_reg & dynEnable_reg);
  assign regSummary = |(regEvent_reg & regEnable_reg);

  always_comb
  begin
    quesCond = questionableIn;
    // Detail summaries at bits 8 and 10
    quesCond[`QUES_DYN_BIT]    = dynSummary;
    quesCond[`QUES_LOSS_BIT]   = regSummary;
    quesCond[`QUES_UNUSED_BIT] = 1'b0;
  end

  // Either direction passes when both set
  assign dynHit  = qualify(dynPrev_reg, dynCond, dynRise_reg, dynFall_reg);
  assign regHit  = qualify(regPrev_reg, regCond, regRise_reg, regFall_reg);
  assign quesHit = qualify(quesPrev_reg, quesCond, quesRise_reg, quesFall_reg);

  always_comb
  begin
    stdHit = '0;
    stdHit[`STD_OPC_BIT]     = operationComplete;
    stdHit[`STD_QUERY_BIT]   = emptyBufferRead | replyInterrupted | buffersFull;
    stdHit[`STD_DEVICE_BIT]  = deviceError;
    stdHit[`STD_EXEC_BIT]    = executionError;
    stdHit[`STD_COMMAND_BIT] = commandError;
  end

  // Previous condition for edge detection
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dynPrev_reg  <= '0;
      regPrev_reg  <= '0;
      quesPrev_reg <= '0;
    end
    else
    begin
      dynPrev_reg  <= dynCond;
      regPrev_reg  <= regCond;
      quesPrev_reg <= quesCond;
    end
  end

  // Read clears, but new hits win
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dynEvent_reg  <= '0;
      regEvent_reg  <= '0;
      quesEvent_reg <= '0;
    end
    else
    begin
      dynEvent_reg  <= (readsEvent(regRead, selGroup, `SEL_GROUP_DYN, selKind) ? '0 : dynEvent_reg) | dynHit;
      regEvent_reg  <= (readsEvent(regRead, selGroup, `SEL_GROUP_REG, selKind) ? '0 : regEvent_reg) | regHit;
      quesEvent_reg <= (readsEvent(regRead, selGroup, `SEL_GROUP_QUES, selKind) ? '0 : quesEvent_reg) | quesHit;
    end
  end

  // Power-on bit set by reset, cleared on read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      stdEvent_reg <= `RST_STD_EVENT;
    else
      stdEvent_reg <= (readsEvent(regRead, selGroup, `SEL_GROUP_STD, selKind) ? '0 : stdEvent_reg) | stdHit;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dynRise_reg    <= `RST_RISE;
      regRise_reg    <= `RST_RISE;
      quesRise_reg   <= `RST_RISE;
      dynFall_reg    <= `RST_FALL;
      regFall_reg    <= `RST_FALL;
      quesFall_reg   <= `RST_FALL;
      dynEnable_reg  <= `RST_MASK;
      regEnable_reg  <= `RST_MASK;
      quesEnable_reg <= `RST_MASK;
      stdEnable_reg  <= `RST_MASK;
    end
    else if (regWrite)
    begin
      unique case ({selGroup, selKind})
        {`SEL_GROUP_DYN, `SEL_KIND_RISE}:    dynRise_reg    <= regWriteData;
        {`SEL_GROUP_DYN, `SEL_KIND_FALL}:    dynFall_reg    <= regWriteData;
        {`SEL_GROUP_DYN, `SEL_KIND_ENABLE}:  dynEnable_reg  <= regWriteData;
        {`SEL_GROUP_REG, `SEL_KIND_RISE}:    regRise_reg    <= regWriteData;
        {`SEL_GROUP_REG, `SEL_KIND_FALL}:    regFall_reg    <= regWriteData;
        {`SEL_GROUP_REG, `SEL_KIND_ENABLE}:  regEnable_reg  <= regWriteData;
        {`SEL_GROUP_QUES, `SEL_KIND_RISE}:   quesRise_reg   <= regWriteData;
        {`SEL_GROUP_QUES, `SEL_KIND_FALL}:   quesFall_reg   <= regWriteData;
        {`SEL_GROUP_QUES, `SEL_KIND_ENABLE}: quesEnable_reg <= regWriteData;
        {`SEL_GROUP_STD, `SEL_KIND_ENABLE}:  stdEnable_reg  <= regWriteData;
        // Condition and event registers are read-only
        default: ;
      endcase
    end
  end

  // Read port, answered one cycle after the strobe
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      regReadData  <= '0;
      regReadValid <= 1'b0;
    end
    else
    begin
      regReadValid <= regRead;
      if (regRead)
      begin
        unique case ({selGroup, selKind})
          {`SEL_GROUP_DYN, `SEL_KIND_COND}:    regReadData <= dynCond;
          {`SEL_GROUP_DYN, `SEL_KIND_EVENT}:   regReadData <= dynEvent_reg;
          {`SEL_GROUP_DYN, `SEL_KIND_RISE}:    regReadData <= dynRise_reg;
          {`SEL_GROUP_DYN, `SEL_KIND_FALL}:    regReadData <= dynFall_reg;
          {`SEL_GROUP_DYN, `SEL_KIND_ENABLE}:  regReadData <= dynEnable_reg;
          {`SEL_GROUP_REG, `SEL_KIND_COND}:    regReadData <= regCond;
          {`SEL_GROUP_REG, `SEL_KIND_EVENT}:   regReadData <= regEvent_reg;
          {`SEL_GROUP_REG, `SEL_KIND_RISE}:    regReadData <= regRise_reg;
          {`SEL_GROUP_REG, `SEL_KIND_FALL}:    regReadData <= regFall_reg;
          {`SEL_GROUP_REG, `SEL_KIND_ENABLE}:  regReadData <= regEnable_reg;
          {`SEL_GROUP_QUES, `SEL_KIND_COND}:   regReadData <= quesCond;
          {`SEL_GROUP_QUES, `SEL_KIND_EVENT}:  regReadData <= quesEvent_reg;
          {`SEL_GROUP_QUES, `SEL_KIND_RISE}:   regReadData <= quesRise_reg;
          {`SEL_GROUP_QUES, `SEL_KIND_FALL}:   regReadData <= quesFall_reg;
          {`SEL_GROUP_QUES, `SEL_KIND_ENABLE}: regReadData <= quesEnable_reg;
          {`SEL_GROUP_STD, `SEL_KIND_EVENT}:   regReadData <= stdEvent_reg;
          {`SEL_GROUP_STD, `SEL_KIND_ENABLE}:  regReadData <= stdEnable_reg;
          // Unmapped selectors read as zero
          default:                             regReadData <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dynamic_protection_summary <= 1'b0;
      out_of_regulation_summary  <= 1'b0;
      questionableSummary        <= 1'b0;
      standardSummary            <= 1'b0;
    end
    else
    begin
      dynamic_protection_summary <= dynSummary;
      out_of_regulation_summary  <= regSummary;
      questionableSummary        <= |(quesEvent_reg & quesEnable_reg);
      standardSummary            <= |(stdEvent_reg & stdEnable_reg);
    end
  end

  a_rise_passes: assert property (@(posedge clock) disable iff (rst)
    (quesRise_reg[0] && quesCond[0] && !quesPrev_reg[0]) |=> quesEvent_reg[0])
    else $error("qualified rising edge not latched");

  a_fall_passes: assert property (@(posedge clock) disable iff (rst)
    (quesFall_reg[1] && !quesCond[1] && quesPrev_reg[1]) |=> quesEvent_reg[1])
    else $error("qualified falling edge not latched");

  a_event_holds: assert property (@(posedge clock) disable iff (rst)
    (dynEvent_reg[0] && !readsEvent(regRead, selGroup, `SEL_GROUP_DYN, selKind)) |=> dynEvent_reg[0])
    else $error("event bit dropped without a read");

  a_read_clears: assert property (@(posedge clock) disable iff (rst)
    (readsEvent(regRead, selGroup, `SEL_GROUP_REG, selKind) && regHit == '0)
      |=> (regEvent_reg == '0 && regReadValid && regReadData == $past(regEvent_reg)))
    else $error("event read did not return and clear");

  a_no_lost_event: assert property (@(posedge clock) disable iff (rst)
    (readsEvent(regRead, selGroup, `SEL_GROUP_DYN, selKind) && dynHit[0]) |=> dynEvent_reg[0])
    else $error("event lost in read cycle");

  a_cond_live: assert property (@(posedge clock) disable iff (rst)
    (regRead && {selGroup, selKind} == {`SEL_GROUP_QUES, `SEL_KIND_COND}) |=> regReadData == $past(quesCond))
    else $error("condition read not live");

  a_dyn_feed: assert property (@(posedge clock) disable iff (rst)
    ($rose(dynSummary) && quesRise_reg[`QUES_DYN_BIT]) |=> quesEvent_reg[`QUES_DYN_BIT])
    else $error("dynamic summary not at questionable bit");

  a_loss_feed: assert property (@(posedge clock) disable iff (rst)
    ($rose(regSummary) && quesRise_reg[`QUES_LOSS_BIT]) |=> quesEvent_reg[`QUES_LOSS_BIT])
    else $error("regulation summary not at questionable bit");

  a_ques_summary: assert property (@(posedge clock) disable iff (rst)
    ##1 questionableSummary == |($past(quesEvent_reg) & $past(quesEnable_reg)))
    else $error("questionable summary mismatch");

  a_opc_sets: assert property (@(posedge clock) disable iff (rst)
    operationComplete |=> stdEvent_reg[`STD_OPC_BIT])
    else $error("operation complete not latched");

  a_std_mask: assert property (@(posedge clock) disable iff (rst)
    (stdEnable_reg == '0) |=> !standardSummary)
    else $error("masked standard events reached summary");

endmodule : status_event_reporting
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "status_event_map.svh"
module tb
  import status_event_pkg::*;
;
  logic              clock;
  logic              rst;
  status_select_type regSelect;
  logic              regRead;
  logic              regWrite;
  status_word_type   regWriteData;
  status_word_type   regReadData;
  logic              regReadValid;
  status_word_type   questionableIn;
  logic [6:0]        dynIn;
  logic [6:0]        stdPulse;
  logic [8:0]        regIn;
  logic              dynSum;
  logic              regSum;
  logic              quesSum;
  logic              stdSum;
  int                errCount;
  int                samplesChecked;

  status_event_reporting #(.DataWidth(16)) u_dut (
    .clock(clock), .rst(rst), .regSelect(regSelect), .regRead(regRead), .regWrite(regWrite),
    .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
    .switching_rate_trip(dynIn[0]), .ringing_trip(dynIn[1]), .modulator_high_clamp_trip(dynIn[2]),
    .modulator_low_clamp_trip(dynIn[3]), .modulator_any_clamp_trip(dynIn[4]),
    .dynamic_current_trip(dynIn[5]), .dynamic_power_trip(dynIn[6]),
    .peak_current_high_limit(regIn[0]), .peak_current_low_limit(regIn[1]),
    .modulator_high_saturation(regIn[2]), .modulator_low_saturation(regIn[3]),
    .peak_power_high_limit(regIn[4]), .peak_power_low_limit(regIn[5]),
    .peak_voltage_high_limit(regIn[6]), .peak_voltage_low_limit(regIn[7]),
    .bottom_resistance_reserved(regIn[8]), .questionableIn(questionableIn),
    .operationComplete(stdPulse[0]), .emptyBufferRead(stdPulse[1]), .replyInterrupted(stdPulse[2]),
    .buffersFull(stdPulse[3]), .deviceError(stdPulse[4]), .executionError(stdPulse[5]),
    .commandError(stdPulse[6]), .dynamic_protection_summary(dynSum),
    .out_of_regulation_summary(regSum), .questionableSummary(quesSum), .standardSummary(stdSum)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stopTest

  task automatic chk(input status_word_type seen, input status_word_type exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input status_select_type sel, input status_word_type exp, input int doChk);
    @(posedge clock);
    regSelect <= sel;
    regRead   <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    if (doChk)
    begin
      chk(regReadData, exp);
      chk({15'h0000, regReadValid}, 16'h0001);
    end
  endtask : rd

  task automatic wr(input status_select_type sel, input status_word_type data);
    @(posedge clock);
    regSelect    <= sel;
    regWriteData <= data;
    regWrite     <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr

  // Inputs held three cycles so every level lasts past the edge detector
  task automatic drv(input logic [1:0] g, input status_word_type v);
    @(posedge clock);
    if (g == `SEL_GROUP_DYN)
      dynIn <= v[6:0];
    else
      regIn <= v[8:0];
    repeat (3) @(posedge clock);
    #1;
  endtask : drv

  function automatic status_word_type edges(input status_word_type a, b, ri, fa);
    return (ri & b & ~a) | (fa & a & ~b);
  endfunction : edges

  function automatic logic gsum(input logic [1:0] g);
    return (g == `SEL_GROUP_DYN) ? dynSum : regSum;
  endfunction : gsum

  function automatic int stdBit(input int i);
    int pos[7] = '{`STD_OPC_BIT, 2, 2, `STD_QUERY_BIT, `STD_DEVICE_BIT, `STD_EXEC_BIT, `STD_COMMAND_BIT};
    return pos[i];
  endfunction : stdBit

  task automatic grpTest(input logic [1:0] g, input status_word_type m);
    status_word_type v0, v1, ri, fa, q;
    int              k;
    // First three passes: rising only, falling only, both; then random filters
    for (int i = 0; i < 6; i++)
    begin
      ri = (i == 1) ? 16'h0000 : (i < 3) ? 16'hFFFF : status_word_type'($urandom);
      fa = (i == 0) ? 16'h0000 : (i < 3) ? 16'hFFFF : status_word_type'($urandom);
      wr({g, `SEL_KIND_RISE}, ri);
      wr({g, `SEL_KIND_FALL}, fa);
      v0 = status_word_type'($urandom) & m;
      v1 = status_word_type'($urandom) & m;
      drv(g, v0);
      rd({g, `SEL_KIND_COND}, v0, 1);
      rd({g, `SEL_KIND_EVENT}, 16'h0000, 0);
      drv(g, v1);
      drv(g, v0);
      rd({g, `SEL_KIND_EVENT}, (edges(v0, v1, ri, fa) | edges(v1, v0, ri, fa)) & m, 1);
      rd({g, `SEL_KIND_EVENT}, 16'h0000, 1);
    end
    k = $urandom % 7;
    wr({g, `SEL_KIND_RISE}, 16'hFFFF);
    wr({g, `SEL_KIND_FALL}, 16'h0000);
    wr({g, `SEL_KIND_ENABLE}, m & ~(16'h0001 << k));
    drv(g, 16'h0000);
    rd({g, `SEL_KIND_EVENT}, 16'h0000, 0);
    rd({`SEL_GROUP_QUES, `SEL_KIND_EVENT}, 16'h0000, 0);
    drv(g, 16'h0001 << k);
    chk({15'h0000, gsum(g)}, 16'h0000);
    chk({15'h0000, quesSum}, 16'h0000);
    wr({g, `SEL_KIND_ENABLE}, 16'h0001 << k);
    repeat (4) @(posedge clock);
    #1;
    chk({15'h0000, gsum(g)}, 16'h0001);
    chk({15'h0000, quesSum}, 16'h0001);
    q = (g == `SEL_GROUP_DYN) ? 16'h0100 : 16'h0400;
    rd({`SEL_GROUP_QUES, `SEL_KIND_COND}, (questionableIn & 16'h7AFF) | q, 1);
    wr({g, `SEL_KIND_ENABLE}, 16'h0000);
  endtask : grpTest

  task automatic pulse(input int i);
    @(posedge clock);
    stdPulse <= 7'h01 << i;
    @(posedge clock);
    stdPulse <= 7'h00;
  endtask : pulse

  initial
  begin
    #3000000;
    errCount++;
    stopTest();
  end

  initial
  begin
    errCount       = 0;
    samplesChecked = 0;
    rst            = 1'b1;
    regSelect      = 5'h00;
    regRead        = 1'b0;
    regWrite       = 1'b0;
    regWriteData   = 16'h0000;
    dynIn          = 7'h00;
    regIn          = 9'h000;
    stdPulse       = 7'h00;
    void'($urandom(32'h83BC59CE));
    questionableIn = status_word_type'($urandom);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd({`SEL_GROUP_STD, `SEL_KIND_EVENT}, `RST_STD_EVENT, 1);
    rd({`SEL_GROUP_STD, `SEL_KIND_EVENT}, 16'h0000, 1);
    rd({`SEL_GROUP_QUES, `SEL_KIND_RISE}, `RST_RISE, 1);
    rd({`SEL_GROUP_QUES, `SEL_KIND_FALL}, `RST_FALL, 1);
    rd({`SEL_GROUP_STD, `SEL_KIND_ENABLE}, `RST_MASK, 1);
    rd({`SEL_GROUP_DYN, 3'h5}, 16'h0000, 1);
    wr({`SEL_GROUP_QUES, `SEL_KIND_ENABLE}, 16'h0500);
    rd({`SEL_GROUP_QUES, `SEL_KIND_ENABLE}, 16'h0500, 1);
    grpTest(`SEL_GROUP_DYN, 16'h007F);
    grpTest(`SEL_GROUP_REG, 16'h01FF);
    // Questionable group: bit 0 rises and bit 1 falls together
    wr({`SEL_GROUP_QUES, `SEL_KIND_FALL}, 16'hFFFF);
    questionableIn <= (questionableIn & 16'hFFFC) | 16'h0002;
    rd({`SEL_GROUP_QUES, `SEL_KIND_EVENT}, 16'h0000, 0);
    @(posedge clock);
    questionableIn <= (questionableIn & 16'hFFFC) | 16'h0001;
    repeat (2) @(posedge clock);
    rd({`SEL_GROUP_QUES, `SEL_KIND_EVENT}, 16'h0003, 1);
    // Writes to the standard event latch must be dropped
    wr({`SEL_GROUP_STD, `SEL_KIND_EVENT}, 16'hFFFF);
    rd({`SEL_GROUP_STD, `SEL_KIND_EVENT}, 16'h0000, 1);
    for (int i = 0; i < 7; i++)
    begin
      pulse(i);
      repeat (2) @(posedge clock);
      rd({`SEL_GROUP_STD, `SEL_KIND_EVENT}, 16'h0001 << stdBit(i), 1);
    end
    pulse(5);
    wr({`SEL_GROUP_STD, `SEL_KIND_ENABLE}, 16'h0010);
    repeat (3) @(posedge clock);
    #1;
    chk({15'h0000, stdSum}, 16'h0001);
    wr({`SEL_GROUP_STD, `SEL_KIND_ENABLE}, 16'h0020);
    repeat (3) @(posedge clock);
    #1;
    chk({15'h0000, stdSum}, 16'h0000);
    // Pulse lands on the same edge as the clearing read
    @(posedge clock);
    stdPulse[6] <= 1'b1;
    regSelect   <= {`SEL_GROUP_STD, `SEL_KIND_EVENT};
    regRead     <= 1'b1;
    @(posedge clock);
    stdPulse[6] <= 1'b0;
    regRead     <= 1'b0;
    #1;
    chk(regReadData, 16'h0010);
    repeat (2) @(posedge clock);
    rd({`SEL_GROUP_STD, `SEL_KIND_EVENT}, 16'h0020, 1);
    stopTest();
  end
endmodule : tb
`default_nettype wire
